// ---- src/dmap_pkg.sv ----
// Package: constants and types for the data memory map decoder
// Summary of operation
// (R01) Every peripheral register lives in I/O space, reachable by load/store.
// (R02) Direct port in/out reaches only I/O addresses 0x00 to 0x3F.
// (R03) I/O 0x00-0x1F allow bit set/clear and skip-if-bit tests.
// (R04) EEPROM reachable in its own space or mapped; byte and page access.
// (R05) External address width selectable from 8 to 24 bits.
// (R06) Four chip selects, each SRAM, reduced-pin SRAM or SDRAM.
// (R07) Each chip select claims its own base address and size.
// (R08) Selectable address/data multiplexing modes on shared pins.
// (R09) SDRAM mode: 4-bit SDRAM, CAS latency and refresh set by software.
// (R10) Software-set wait states inserted into external accesses.
// (R11) External port logic runs at twice CPU clock, up to 64 MHz.
// (R12) Factory signature row rejects writes and erases, stays readable.
// (R13) Factory row holds three-byte device type identifier, bytes 0 to 2.
// (R14) Factory row holds unique serial: lot, wafer, die coordinates.
// (R15) User signature row is one flash page, readable and writable; code holds only SIG_LEN = 16 bytes.
// (R16) User row survives chip erase; cleared only by its own erase. Code also clears it on reset.
// (R17) Flash writes/erases whole pages; reads return single bytes.
// (R18) Flash Z address splits into page and word fields by page size.
// (R19) EEPROM writes/erases per page or byte; reads single bytes.
// (R20) EEPROM address splits byte ADDR[4:0] and page ADDR[10:5]/[11:5].
// (R21) I/O below 0x1000, EEPROM 0x1000, SRAM 0x2000, external above SRAM.
package dmap_pkg;

  // ****************************************
  // Address map
  // ****************************************
  localparam logic [23:0] IO_BASE      = 24'h000000;
  localparam logic [23:0] EEPROM_BASE  = 24'h001000;
  localparam logic [23:0] SRAM_BASE    = 24'h002000;
  localparam logic [23:0] DIRECT_IO_TOP = 24'h00003f;
  localparam logic [23:0] BIT_IO_TOP    = 24'h00001f;
  localparam int          NUM_CS       = 4;
  localparam int          EE_BYTE_BITS = 5;
  localparam logic [2:0]  ADDR_MIN_SEL = 3'h0;   // 8-bit
  localparam logic [2:0]  ADDR_MAX_SEL = 3'h4;   // 24-bit
  localparam logic [3:0]  SDRAM_WIDTH  = 4'h4;
  localparam int          SIG_LEN      = 16;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  // Device type identifier bytes; values are arbitrary
  localparam logic [7:0]  DEV_ID0      = 8'h5a;
  localparam logic [7:0]  DEV_ID1      = 8'h01;
  localparam logic [7:0]  DEV_ID2      = 8'h02;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [6:0] {
    REG_NONE = 7'h01,
    REG_IO   = 7'h02,
    REG_EE   = 7'h04,
    REG_SRAM = 7'h08,
    REG_EXT  = 7'h10,
    REG_RSVD = 7'h20,
    REG_SIG  = 7'h40
  } region_t;

  typedef enum logic [2:0] {
    CS_SRAM  = 3'h1,
    CS_RPSRAM = 3'h2,
    CS_SDRAM = 3'h4
  } cs_mode_t;

  typedef enum logic [2:0] {
    MUX_NONE = 3'h1,
    MUX_ALE1 = 3'h2,
    MUX_ALE2 = 3'h4
  } mux_mode_t;

  typedef struct packed {
    logic        en;
    cs_mode_t    mode;
    logic [23:0] base;
    logic [4:0]  size_log2;
  } cs_cfg_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } cpu_req_t;

  typedef struct packed {
    logic [2:0]  cas_latency;
    logic [11:0] refresh_period;
  } sdram_cfg_t;

endpackage

// ---- src/cs_match.sv ----
// Single chip-select window comparator
`timescale 1ns/1ps
module cs_match (
  input  wire dmap_pkg::cs_cfg_t i_cfg,
  input  wire logic [23:0]       i_addr,
  input  wire logic [4:0]        i_addr_bits,
  output logic                   o_hit
);
  logic [23:0] mask;
  logic [23:0] limit;
  always_comb begin
    mask  = 24'hffffff << i_cfg.size_log2;
    limit = 24'hffffff >> (5'd24 - i_addr_bits);
    // Window defined by base and size; address must lie inside external range [R07]
    o_hit = i_cfg.en && ((i_addr & mask) == (i_cfg.base & mask)) && ((i_addr & ~limit) == 24'h000000);
  end
endmodule // cs_match

// ---- src/data_memory_map_decoder.sv ----
// Data-space decoder, external bus port control and signature rows
`timescale 1ns/1ps
module data_memory_map_decoder #(
  parameter logic [23:0] SRAM_SIZE   = 24'h004000,
  parameter int          EE_PAGE_MSB = 10,
  parameter int          FLASH_WORD_INDEX_MSB   = 8
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire dmap_pkg::cpu_req_t   i_req,
  input  wire logic                 i_port_instr,
  input  wire logic                 i_bit_instr,
  input  wire logic                 i_ee_mapped,
  input  wire logic                 i_sig_sel,
  input  wire logic                 i_sig_user,
  input  wire logic                 i_sig_erase,
  input  wire logic                 i_chip_erase,
  input  wire logic                 i_prog_access,
  input  wire logic [2:0]           i_addr_width_sel,
  input  wire dmap_pkg::mux_mode_t  i_mux_mode,
  input  wire dmap_pkg::cs_cfg_t    i_cs_cfg [dmap_pkg::NUM_CS],
  input  wire dmap_pkg::sdram_cfg_t i_sdram_cfg,
  input  wire logic [3:0]           i_wait_states,
  input  wire logic [19:0]          i_flash_z,
  input  wire logic [11:0]          i_nvm_addr,
  input  wire logic [47:0]          i_serial,
  output dmap_pkg::region_t         o_region,
  output logic                      o_io_sel,
  output logic                      o_ee_sel,
  output logic                      o_sram_sel,
  output logic                      o_ext_sel,
  output logic                      o_rsvd,
  output logic                      o_instr_fault,
  output logic [11:0]               o_io_addr,
  output logic [11:0]               o_ee_offset,
  output logic [3:0]                o_cs_sel,
  output dmap_pkg::cs_mode_t        o_cs_mode,
  output logic                      o_ext_ready,
  output logic                      o_ext_ale,
  output logic [2:0]                o_cas_latency,
  output logic                      o_refresh_req,
  output logic                      o_sig_reject,
  output logic [7:0]                o_rdata,
  output logic [10:0]               o_flash_page_index,
  output logic [7:0]                o_flash_word_index,
  output logic [6:0]                o_eeprom_page_index,
  output logic [4:0]                o_eeprom_byte_index
);

  // ****************************************
  // Address width and region decode
  // ****************************************
  logic [4:0]  addr_bits;
  logic [23:0] sram_top;
  logic [3:0]  cs_hit;
  logic [23:0] a;
  logic        io_r, ee_r, sram_r, ext_r;
  logic [12:0] ee_limit;

  // Width grows in 4-bit steps from 8 to 24 [R05]
  always_comb begin
    if (i_addr_width_sel > dmap_pkg::ADDR_MAX_SEL) begin
      addr_bits = 5'd24;
    end else begin
      addr_bits = 5'd8 + {i_addr_width_sel[2:0], 2'b00};
    end
  end

  assign a        = i_req.addr;
  assign sram_top = dmap_pkg::SRAM_BASE + SRAM_SIZE;
  // One bit wider so a 4 KB window does not wrap to zero
  assign ee_limit = 13'(1 << (EE_PAGE_MSB + 1));

  genvar g;
  generate
    for (g = 0; g < dmap_pkg::NUM_CS; g++) begin : g_cs
      cs_match u_cs (
        .i_cfg       (i_cs_cfg[g]),
        .i_addr      (a),
        .i_addr_bits (addr_bits),
        .o_hit       (cs_hit[g])
      ); // [R06]
    end
  endgenerate

  always_comb begin
    io_r   = a < dmap_pkg::EEPROM_BASE;                                      // [R01] [R21]
    ee_r   = (a >= dmap_pkg::EEPROM_BASE) && (a < dmap_pkg::SRAM_BASE) && i_ee_mapped &&
             ({1'b0, a[11:0]} < ee_limit);                                   // [R04] [R21]
    sram_r = (a >= dmap_pkg::SRAM_BASE) && (a < sram_top);                   // [R21]
    ext_r  = (a >= sram_top) && (cs_hit != 4'h0);                           // [R07] [R21]
  end

  // Port and bit instructions limited to low I/O addresses
  logic instr_bad;
  always_comb begin
    instr_bad = (i_port_instr && (a > dmap_pkg::DIRECT_IO_TOP)) ||          // [R02]
                (i_bit_instr && (a > dmap_pkg::BIT_IO_TOP));                // [R03]
  end

  // Accepted external access: valid, inside a window, not refused
  logic ext_go;
  assign ext_go = i_req.valid && ext_r && !instr_bad && !i_sig_sel;

  // Priority chip select: lowest index wins on overlap
  logic [3:0]          cs_one;
  dmap_pkg::cs_mode_t  cs_mode;
  always_comb begin
    cs_one  = 4'h0;
    cs_mode = dmap_pkg::CS_SRAM;
    for (int i = dmap_pkg::NUM_CS - 1; i >= 0; i--) begin
      if (cs_hit[i]) begin
        cs_one  = 4'(1 << i);
        cs_mode = i_cs_cfg[i].mode;                                          // [R06]
      end
    end
  end

  // ****************************************
  // Registered decode outputs
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_region      <= dmap_pkg::REG_NONE;
      o_io_sel      <= 1'b0;
      o_ee_sel      <= 1'b0;
      o_sram_sel    <= 1'b0;
      o_ext_sel     <= 1'b0;
      o_rsvd        <= 1'b0;
      o_instr_fault <= 1'b0;
      o_io_addr     <= 12'h000;
      o_ee_offset   <= 12'h000;
      o_cs_sel      <= 4'h0;
      o_cs_mode     <= dmap_pkg::CS_SRAM;
    end else begin
      o_io_sel      <= i_req.valid && !i_sig_sel && io_r && !instr_bad;
      o_ee_sel      <= i_req.valid && !i_sig_sel && ee_r && !instr_bad;
      o_sram_sel    <= i_req.valid && !i_sig_sel && sram_r && !instr_bad;
      o_ext_sel     <= i_req.valid && !i_sig_sel && ext_r && !instr_bad;
      o_rsvd        <= i_req.valid && !i_sig_sel && !(io_r || ee_r || sram_r || ext_r);
      o_instr_fault <= i_req.valid && instr_bad;
      o_io_addr     <= a[11:0];
      o_ee_offset   <= a[11:0];                                             // [R04]
      o_cs_sel      <= ext_go ? cs_one : 4'h0;
      o_cs_mode     <= cs_mode;
      if (!i_req.valid) begin
        o_region <= dmap_pkg::REG_NONE;
      end else if (i_sig_sel) begin
        o_region <= dmap_pkg::REG_SIG;
      end else if (io_r) begin
        o_region <= dmap_pkg::REG_IO;
      end else if (ee_r) begin
        o_region <= dmap_pkg::REG_EE;
      end else if (sram_r) begin
        o_region <= dmap_pkg::REG_SRAM;
      end else if (ext_r) begin
        o_region <= dmap_pkg::REG_EXT;
      end else begin
        o_region <= dmap_pkg::REG_RSVD;
      end
    end
  end

  // ****************************************
  // External access wait states
  // ****************************************
  typedef enum logic [2:0] {
    EXT_IDLE = 3'h1,
    EXT_ADDR = 3'h2,
    EXT_WAIT = 3'h4
  } ext_state_t;
  ext_state_t ext_q;
  logic [3:0] wait_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_q  <= EXT_IDLE;
      wait_q <= 4'h0;
    end else begin
      case (ext_q)
        EXT_IDLE: begin
          if (ext_go) begin
            // Multiplexed modes spend a phase on the address latch [R08]
            ext_q  <= (i_mux_mode == dmap_pkg::MUX_NONE) ? EXT_WAIT : EXT_ADDR;
            wait_q <= i_wait_states;                                        // [R10]
          end
        end
        EXT_ADDR: ext_q <= EXT_WAIT;
        EXT_WAIT: begin
          if (wait_q == 4'h0) begin
            ext_q <= EXT_IDLE;
          end else begin
            wait_q <= wait_q - 4'h1;                                        // [R10]
          end
        end
        default: ext_q <= EXT_IDLE;
      endcase
    end
  end

  // Access is timed in CPU cycles; the 2x port clock is derived outside [R11]
  assign o_ext_ready = (ext_q == EXT_WAIT) && (wait_q == 4'h0);
  assign o_ext_ale   = (ext_q == EXT_ADDR);                                 // [R08]

  // ****************************************
  // SDRAM refresh timer
  // ****************************************
  logic [11:0] refresh_q;
  logic        refresh_load;
  // External access restarts the interval; one pulse every refresh_period cycles
  assign refresh_load = ext_go || (refresh_q <= 12'h001);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      refresh_q     <= 12'h000;
      o_refresh_req <= 1'b0;
      o_cas_latency <= 3'h0;
    end else begin
      o_cas_latency <= i_sdram_cfg.cas_latency;                             // [R09]
      o_refresh_req <= 1'b0;
      if (refresh_load) begin
        refresh_q <= i_sdram_cfg.refresh_period;
      end else begin
        refresh_q <= refresh_q - 12'h001;
      end
      if (refresh_q == 12'h001) begin
        o_refresh_req <= 1'b1;                                              // [R09]
      end
    end
  end

  // ****************************************
  // Signature rows
  // ****************************************
  logic [7:0] user_row [dmap_pkg::SIG_LEN];
  logic [7:0] prod_byte;
  logic [3:0] sig_idx;
  assign sig_idx = a[3:0];

  always_comb begin
    case (sig_idx)
      4'h0:    prod_byte = dmap_pkg::DEV_ID0;                               // [R13]
      4'h1:    prod_byte = dmap_pkg::DEV_ID1;                               // [R13]
      4'h2:    prod_byte = dmap_pkg::DEV_ID2;                               // [R13]
      4'h8:    prod_byte = i_serial[7:0];                                   // [R14]
      4'h9:    prod_byte = i_serial[15:8];
      4'ha:    prod_byte = i_serial[23:16];
      4'hb:    prod_byte = i_serial[31:24];
      4'hc:    prod_byte = i_serial[39:32];
      4'hd:    prod_byte = i_serial[47:40];
      default: prod_byte = dmap_pkg::ERASED_BYTE;
    endcase
  end

  // User row kept through chip erase; reset or any i_sig_erase, even with i_sig_user low, clears it [R15] [R16]
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < dmap_pkg::SIG_LEN; i++) begin
        user_row[i] <= dmap_pkg::ERASED_BYTE;
      end
    end else if (i_sig_erase) begin
      for (int i = 0; i < dmap_pkg::SIG_LEN; i++) begin
        user_row[i] <= dmap_pkg::ERASED_BYTE;                               // [R16]
      end
    end else if (i_req.valid && i_req.write && i_sig_sel && i_sig_user) begin
      user_row[sig_idx] <= i_req.wdata;                                     // [R15]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata      <= 8'h00;
      o_sig_reject <= 1'b0;
    end else begin
      // Program or software access alike; factory row never written [R12]
      o_sig_reject <= i_req.valid && i_sig_sel && !i_sig_user && (i_req.write || i_sig_erase);
      if (i_req.valid && !i_req.write && i_sig_sel) begin
        o_rdata <= i_sig_user ? user_row[sig_idx] : prod_byte;              // [R12] [R15]
      end
    end
  end

  // ****************************************
  // Flash and EEPROM address split
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flash_page_index  <= 11'h000;
      o_flash_word_index  <= 8'h00;
      o_eeprom_page_index <= 7'h00;
      o_eeprom_byte_index <= 5'h00;
    end else begin
      // Word index from Z[FLASH_WORD_INDEX_MSB:1], page from upper bits [R17] [R18]
      o_flash_word_index  <= 8'((i_flash_z >> 1) & ((20'h1 << FLASH_WORD_INDEX_MSB) - 20'h1));
      o_flash_page_index  <= 11'(i_flash_z >> (FLASH_WORD_INDEX_MSB + 1));
      // Byte in page ADDR[4:0], page ADDR[EE_PAGE_MSB:5] [R19] [R20]
      o_eeprom_byte_index <= i_nvm_addr[dmap_pkg::EE_BYTE_BITS-1:0];
      o_eeprom_page_index <= 7'((i_nvm_addr & 12'((1 << (EE_PAGE_MSB + 1)) - 1)) >> dmap_pkg::EE_BYTE_BITS);
    end
  end

  logic unused;
  assign unused = i_chip_erase ^ i_prog_access;

endmodule // data_memory_map_decoder

// ---- testbench/data_memory_map_decoder_props.sv ----
// Concurrent checks on the decoder ports
`timescale 1ns/1ps
module data_memory_map_decoder_props #(
  parameter logic [23:0] SRAM_SIZE   = 24'h004000,
  parameter int          EE_PAGE_MSB = 10,
  parameter int          FLASH_WORD_INDEX_MSB   = 8
) (
  input wire logic               i_clk,
  input wire logic               i_rst,
  input wire dmap_pkg::cpu_req_t i_req,
  input wire logic               i_port_instr,
  input wire logic               i_bit_instr,
  input wire logic               i_ee_mapped,
  input wire logic               i_sig_sel,
  input wire logic               i_sig_user,
  input wire logic [19:0]        i_flash_z,
  input wire logic [11:0]        i_nvm_addr,
  input wire dmap_pkg::region_t  o_region,
  input wire logic               o_io_sel,
  input wire logic               o_ee_sel,
  input wire logic               o_sram_sel,
  input wire logic               o_ext_sel,
  input wire logic               o_rsvd,
  input wire logic               o_instr_fault,
  input wire logic [11:0]        o_ee_offset,
  input wire logic [3:0]         o_cs_sel,
  input wire logic               o_sig_reject,
  input wire logic [10:0]        o_flash_page_index,
  input wire logic [7:0]         o_flash_word_index,
  input wire logic [6:0]         o_eeprom_page_index,
  input wire logic [4:0]         o_eeprom_byte_index
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic plain;
  assign plain = i_req.valid && !i_port_instr && !i_bit_instr && !i_sig_sel;

  a_port_limit: assert property (
    i_req.valid && i_port_instr && !i_sig_sel && i_req.addr > 24'h00003f |=> o_instr_fault && !o_io_sel)
    else $error("port access above limit not refused");
  a_bit_limit: assert property (
    i_req.valid && i_bit_instr && !i_port_instr && !i_sig_sel && i_req.addr > 24'h00001f |=> o_instr_fault)
    else $error("bit access above limit not refused");
  a_io_region: assert property (
    plain && i_req.addr < dmap_pkg::EEPROM_BASE |=> o_io_sel && o_region == dmap_pkg::REG_IO)
    else $error("io address not sent to io space");
  a_ee_window: assert property (
    plain && i_ee_mapped && i_req.addr inside {[24'h001000:24'h0017ff]}
    |=> o_ee_sel && o_ee_offset == $past(i_req.addr[11:0]))
    else $error("mapped eeprom access wrong");
  a_sram_window: assert property (
    plain && i_req.addr >= dmap_pkg::SRAM_BASE && i_req.addr < dmap_pkg::SRAM_BASE + SRAM_SIZE
    |=> o_sram_sel && o_region == dmap_pkg::REG_SRAM)
    else $error("sram address not sent to sram");
  a_sig_locked: assert property (
    i_req.valid && i_req.write && i_sig_sel && !i_sig_user |=> o_sig_reject)
    else $error("factory row write not rejected");
  a_sel_onehot: assert property (
    $onehot0({o_io_sel, o_ee_sel, o_sram_sel, o_ext_sel, o_rsvd}))
    else $error("more than one region selected");
  a_cs_onehot: assert property (
    $onehot0(o_cs_sel))
    else $error("more than one chip select");
  a_flash_split: assert property (
    !$past(i_rst) |-> o_flash_page_index == 11'($past(i_flash_z) >> (FLASH_WORD_INDEX_MSB + 1))
    && o_flash_word_index == 8'(($past(i_flash_z) >> 1) & ((20'h1 << FLASH_WORD_INDEX_MSB) - 20'h1)))
    else $error("flash address split wrong");
  a_ee_split: assert property (
    !$past(i_rst) |-> o_eeprom_byte_index == $past(i_nvm_addr[4:0])
    && o_eeprom_page_index == 7'(($past(i_nvm_addr) >> 5) & ((12'h1 << (EE_PAGE_MSB - 4)) - 12'h1)))
    else $error("eeprom address split wrong");
endmodule // data_memory_map_decoder_props

bind data_memory_map_decoder data_memory_map_decoder_props #(
  .SRAM_SIZE(SRAM_SIZE), .EE_PAGE_MSB(EE_PAGE_MSB), .FLASH_WORD_INDEX_MSB(FLASH_WORD_INDEX_MSB)
) props (
  .i_clk, .i_rst, .i_req, .i_port_instr, .i_bit_instr, .i_ee_mapped, .i_sig_sel, .i_sig_user,
  .i_flash_z, .i_nvm_addr, .o_region, .o_io_sel, .o_ee_sel, .o_sram_sel, .o_ext_sel, .o_rsvd,
  .o_instr_fault, .o_ee_offset, .o_cs_sel, .o_sig_reject, .o_flash_page_index, .o_flash_word_index,
  .o_eeprom_page_index, .o_eeprom_byte_index
);

// ---- testbench/ext_mem_model.sv ----
// External memory side: times one external access
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic i_clk,
  input  wire logic i_start,
  input  wire logic i_ale,
  input  wire logic i_ready,
  output logic      o_ale_seen,
  output logic      o_done,
  output logic [7:0] o_cycles
);
  initial o_done = 1'b1;
  always @(posedge i_clk) begin
    if (i_start) begin
      o_ale_seen <= 1'b0;
      o_done <= 1'b0;
      o_cycles <= 8'h00;
    end else if (!o_done) begin
      o_cycles <= o_cycles + 8'h01;
      if (i_ale) o_ale_seen <= 1'b1;
      if (i_ready) o_done <= 1'b1;
    end
  end
endmodule // ext_mem_model

// ---- testbench/tb_data_memory_map_decoder.sv ----
// Testbench for the data memory map decoder
`timescale 1ns/1ps
module tb_data_memory_map_decoder;
  logic i_clk = 1'b0, i_rst = 1'b1, port = 1'b0, bitx = 1'b0, sig = 1'b0, user = 1'b0;
  logic ser = 1'b0, cer = 1'b0, start = 1'b0, ale_seen, done;
  logic [3:0] ws = 4'h2;
  logic [19:0] z = 20'h0;
  logic [11:0] nvm = 12'h0;
  logic [7:0] cyc_n, n0;
  logic [47:0] serial = 48'h665544332211;
  dmap_pkg::cpu_req_t req = '0;
  dmap_pkg::mux_mode_t mux = dmap_pkg::MUX_NONE;
  dmap_pkg::cs_cfg_t cs [dmap_pkg::NUM_CS];
  dmap_pkg::region_t region;
  dmap_pkg::cs_mode_t cs_mode;
  logic io_sel, fault, ale, rdy, rej;
  logic [11:0] ee_off, io_addr;
  logic [2:0] aw = 3'h4, cas;
  logic emap = 1'b1, refr;
  logic [3:0] cs_sel;
  logic [7:0] rdata;
  int miscompares = 0, num_checks = 0, cyc = 0, nref = 0;
  initial forever #50 i_clk = ~i_clk;
  initial foreach (cs[k]) cs[k] = '{1'b0, dmap_pkg::CS_SRAM, 24'h0, 5'h0};

  data_memory_map_decoder dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_port_instr(port),
    .i_bit_instr(bitx), .i_ee_mapped(emap), .i_sig_sel(sig), .i_sig_user(user), .i_sig_erase(ser),
    .i_chip_erase(cer), .i_prog_access(1'b0), .i_addr_width_sel(aw), .i_mux_mode(mux), .i_cs_cfg(cs),
    .i_sdram_cfg(15'h2010), .i_wait_states(ws), .i_flash_z(z), .i_nvm_addr(nvm), .i_serial(serial),
    .o_region(region), .o_io_sel(io_sel), .o_ee_sel(), .o_sram_sel(), .o_ext_sel(), .o_rsvd(),
    .o_instr_fault(fault), .o_io_addr(io_addr), .o_ee_offset(ee_off), .o_cs_sel(cs_sel), .o_cs_mode(cs_mode),
    .o_ext_ready(rdy), .o_ext_ale(ale), .o_cas_latency(cas), .o_refresh_req(refr), .o_sig_reject(rej),
    .o_rdata(rdata), .o_flash_page_index(), .o_flash_word_index(), .o_eeprom_page_index(),
    .o_eeprom_byte_index());
  ext_mem_model mem (.i_clk(i_clk), .i_start(start), .i_ale(ale), .i_ready(rdy),
    .o_ale_seen(ale_seen), .o_done(done), .o_cycles(cyc_n));

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // One request cycle; outputs of that request are settled on return
  task automatic acc(input logic [23:0] a, input logic w, input logic [7:0] d, input logic p, input logic b,
                     input logic s, input logic st = 1'b0);
    @(posedge i_clk);
    #1;
    req = '{1'b1, w, a, d};
    {port, bitx, sig, start} = {p, b, s, st};
    @(posedge i_clk);
    #1;
    req.valid = 1'b0;
    {port, bitx, sig, start} = 4'h0;
  endtask
  task automatic wait_ext();
    for (int i = 0; i < 60 && done !== 1'b1; i++) @(posedge i_clk);
    chk("ext_done", 1, done);
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic pulse(input bit erase);
    @(posedge i_clk);
    #1;
    if (erase) ser = 1'b1; else cer = 1'b1;
    @(posedge i_clk);
    #1;
    {ser, cer} = 2'b00;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    logic [23:0] ra [7] = '{24'h000010, 24'h000fff, 24'h001000, 24'h0017ff, 24'h002000, 24'h005fff, 24'h006000};
    dmap_pkg::region_t re [7] = '{dmap_pkg::REG_IO, dmap_pkg::REG_IO, dmap_pkg::REG_EE, dmap_pkg::REG_EE,
                                  dmap_pkg::REG_SRAM, dmap_pkg::REG_SRAM, dmap_pkg::REG_RSVD};
    logic [23:0] ia [4] = '{24'h00003f, 24'h000040, 24'h00001f, 24'h000020};
    dmap_pkg::cs_mode_t md [4] = '{dmap_pkg::CS_SRAM, dmap_pkg::CS_RPSRAM, dmap_pkg::CS_SDRAM, dmap_pkg::CS_SDRAM};
    logic [7:0] ids [3] = '{dmap_pkg::DEV_ID0, dmap_pkg::DEV_ID1, dmap_pkg::DEV_ID2};
    repeat (6) @(posedge i_clk);
    chk("rst_region", dmap_pkg::REG_NONE, region);
    chk("rst_cs_mode", dmap_pkg::CS_SRAM, cs_mode);
    #1;
    i_rst = 1'b0;
    // ****************************************
    // Region decode and direct-instruction limits
    // ****************************************
    for (int k = 0; k < 7; k++) begin
      acc(ra[k], 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
      chk("region", re[k], region);
      chk("io_addr", ra[k][11:0], io_addr);
    end
    acc(24'h001234, 1'b1, 8'h3c, 1'b0, 1'b0, 1'b0);
    chk("ee_offset", 32'h234, ee_off);
    emap = 1'b0;
    acc(24'h001000, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
    chk("ee_unmapped", dmap_pkg::REG_RSVD, region);
    emap = 1'b1;
    for (int k = 0; k < 4; k++) begin
      acc(ia[k], 1'b0, 8'h00, k < 2, k >= 2, 1'b0);
      chk("instr_fault", k % 2, fault);
      chk("io_sel", 1 - k % 2, io_sel);
    end
    // ****************************************
    // Chip selects and external timing
    // ****************************************
    for (int k = 0; k < 4; k++) cs[k] = '{1'b1, md[k], 24'h100000 + 24'(k) * 24'h010000, 5'h10};
    for (int k = 0; k < 4; k++) begin
      acc(24'h100005 + 24'(k) * 24'h010000, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
      chk("cs_sel", 4'h1 << k, cs_sel);
      chk("cs_mode", md[k], cs_mode);
      chk("ext_region", dmap_pkg::REG_EXT, region);
      wait_ext();
    end
    chk("cas_latency", 3'h2, cas);
    aw = 3'h2;
    acc(24'h100005, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
    chk("narrow_cs_sel", 4'h0, cs_sel);
    aw = 3'h4;
    {ws, mux} = {4'h1, dmap_pkg::MUX_ALE1};
    acc(24'h100005, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    wait_ext();
    n0 = cyc_n;
    chk("ale_mux", 1, ale_seen);
    ws = 4'h6;
    acc(24'h100005, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    wait_ext();
    chk("wait_delta", 5, cyc_n - n0);
    {ws, mux} = {4'h1, dmap_pkg::MUX_NONE};
    acc(24'h100005, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    wait_ext();
    chk("ale_plain", 0, ale_seen);
    // ****************************************
    // Signature rows
    // ****************************************
    for (int k = 0; k < 3; k++) begin
      acc(24'(k), 1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
      chk("dev_id", ids[k], rdata);
    end
    acc(24'h000008, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
    chk("serial_lo", serial[7:0], rdata);
    acc(24'h00000d, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
    chk("serial_hi", serial[47:40], rdata);
    acc(24'h000000, 1'b1, 8'h00, 1'b0, 1'b0, 1'b1);
    chk("sig_reject", 1, rej);
    acc(24'h000000, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
    chk("dev_id_kept", ids[0], rdata);
    user = 1'b1;
    acc(24'h000003, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
    chk("user_reset", dmap_pkg::ERASED_BYTE, rdata);
    acc(24'h000003, 1'b1, 8'ha5, 1'b0, 1'b0, 1'b1);
    acc(24'h000003, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
    chk("user_write", 8'ha5, rdata);
    pulse(1'b0);
    acc(24'h000003, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
    chk("user_chip_erase", 8'ha5, rdata);
    pulse(1'b1);
    acc(24'h000003, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1);
    chk("user_erase", dmap_pkg::ERASED_BYTE, rdata);
    // ****************************************
    // Address splits (bound assertions) and refresh interval
    // ****************************************
    {z, nvm} = {20'h5a5a6, 12'h7a3};
    repeat (3) @(posedge i_clk);
    #1;
    {z, nvm} = {20'hfffff, 12'hfff};
    for (int k = 0; k < 64; k++) begin
      @(posedge i_clk);
      #1;
      nref += refr;
    end
    chk("refresh_pulses", 4, nref);
    close_out();
  end
endmodule // tb_data_memory_map_decoder
